// >>> core/imugr_regs.sv
/*
  imugr_regs: angular-rate output bytes, signal-path reset, wake-on-motion
  control and host control registers behind the serial-interface register port.
  Assumes the serial front end decodes frames into one-cycle read/write strobes
  on I_CLK, and that sensor samples arrive from logic on the same clock.
*/
`timescale 1ns/100ps
module imugr_regs (
  // clock, reset, enable
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_CE,
  // register port
  input  wire logic [7:0]  I_REG_ADDR,
  input  wire logic        I_REG_WR,
  input  wire logic [7:0]  I_REG_WDATA,
  input  wire logic        I_REG_RD,
  output logic      [7:0]  O_REG_RDATA,
  // rate samples from the gyro signal path
  input  wire logic        I_RATE_VALID,
  input  wire logic [15:0] I_RATE_X,
  input  wire logic [15:0] I_RATE_Y,
  input  wire logic [15:0] I_RATE_Z,
  // accel samples and motion settings
  input  wire logic        I_ACCEL_VALID,
  input  wire logic [15:0] I_ACCEL_X,
  input  wire logic [15:0] I_ACCEL_Y,
  input  wire logic [15:0] I_ACCEL_Z,
  input  wire logic [15:0] I_MOTION_THRESH,
  input  wire logic [2:0]  I_MOTION_IRQ_EN,
  // fifo host access
  input  wire logic        I_FIFO_RD_REQ,
  output logic             O_FIFO_RD_GRANT,
  // control outputs
  output logic             O_RATE_PATH_RST,
  output logic             O_ACCEL_PATH_RST,
  output logic             O_TEMP_PATH_RST,
  output logic             O_FIFO_RST,
  output logic             O_FIFO_HOST_EN,
  output logic             O_TWO_WIRE_DIS,
  output logic             O_MOTION_EVENT,
  output logic             O_MOTION_IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic moved(input logic [15:0] cur, input logic [15:0] ref_v,
                                 input logic [15:0] thr);
    logic signed [16:0] diff;
    diff = $signed({cur[15], cur}) - $signed({ref_v[15], ref_v});
    if (diff[16]) begin
      diff = -diff;
    end
    moved = (diff > $signed({1'b0, thr}));
  endfunction : moved

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] rate_x_q, rate_y_q, rate_z_q;
  logic [15:0] ref_x_q, ref_y_q, ref_z_q;
  logic        accel_rst_q, temp_rst_q, all_rst_q;
  logic        mot_en_q, mot_mode_q, mot_rsv_q;
  logic        fifo_en_q, two_wire_dis_q;
  logic [1:0]  fifo_cnt_q;
  logic        event_q;
  logic [7:0]  rdata_q;
  imugr_pkg::imugr_wom_t wom_q, wom_d;

  ////////////////////////////////////////////////////////////////////////
  // decode
  wire wr_path  = I_REG_WR && (I_REG_ADDR == imugr_pkg::ADDR_PATH_RST);
  wire wr_mot   = I_REG_WR && (I_REG_ADDR == imugr_pkg::ADDR_MOTION_CTL);
  wire wr_host  = I_REG_WR && (I_REG_ADDR == imugr_pkg::ADDR_HOST_CTL);
  wire all_go   = wr_host && I_REG_WDATA[imugr_pkg::BIT_ALL_PATHS_RST];
  wire fifo_go  = wr_host && I_REG_WDATA[imugr_pkg::BIT_FIFO_RST];
  wire fifo_on  = (fifo_cnt_q != 2'h0);
  wire [7:0] path_rb = {6'h00, accel_rst_q, temp_rst_q};
  wire [7:0] mot_rb  = {mot_en_q, mot_mode_q, 5'h00, mot_rsv_q};
  wire [7:0] host_rb = {1'b0, fifo_en_q, 1'b0, two_wire_dis_q, 1'b0, fifo_on, 1'b0,
                        all_rst_q};

  wire [7:0] rd_mux =
    (I_REG_ADDR == imugr_pkg::ADDR_RATE_XH)    ? rate_x_q[15:8] :
    (I_REG_ADDR == imugr_pkg::ADDR_RATE_XL)    ? rate_x_q[7:0]  :
    (I_REG_ADDR == imugr_pkg::ADDR_RATE_YH)    ? rate_y_q[15:8] :
    (I_REG_ADDR == imugr_pkg::ADDR_RATE_YL)    ? rate_y_q[7:0]  :
    (I_REG_ADDR == imugr_pkg::ADDR_RATE_ZH)    ? rate_z_q[15:8] :
    (I_REG_ADDR == imugr_pkg::ADDR_RATE_ZL)    ? rate_z_q[7:0]  :
    (I_REG_ADDR == imugr_pkg::ADDR_PATH_RST)   ? path_rb        :
    (I_REG_ADDR == imugr_pkg::ADDR_MOTION_CTL) ? mot_rb         :
    (I_REG_ADDR == imugr_pkg::ADDR_HOST_CTL)   ? host_rb        : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // rate outputs; writes to these addresses are ignored
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rate_x_q <= imugr_pkg::RATE_RESET;
      rate_y_q <= imugr_pkg::RATE_RESET;
      rate_z_q <= imugr_pkg::RATE_RESET;
    end else if (I_CE) begin
      if (all_go) begin
        rate_x_q <= imugr_pkg::RATE_RESET;
        rate_y_q <= imugr_pkg::RATE_RESET;
        rate_z_q <= imugr_pkg::RATE_RESET;
      end else if (I_RATE_VALID) begin
        rate_x_q <= I_RATE_X;
        rate_y_q <= I_RATE_Y;
        rate_z_q <= I_RATE_Z;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers and reset pulses
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      accel_rst_q    <= 1'b0;
      temp_rst_q     <= 1'b0;
      all_rst_q      <= 1'b0;
      {mot_en_q, mot_mode_q, mot_rsv_q} <= 3'h0;
      fifo_en_q      <= 1'b0;
      two_wire_dis_q <= 1'b0;
      fifo_cnt_q     <= 2'h0;
      rdata_q        <= imugr_pkg::CTRL_RESET;
    end else if (I_CE) begin
      accel_rst_q <= wr_path && I_REG_WDATA[imugr_pkg::BIT_ACCEL_RST];
      temp_rst_q  <= wr_path && I_REG_WDATA[imugr_pkg::BIT_TEMP_RST];
      all_rst_q   <= all_go;
      if (wr_mot) begin
        mot_en_q   <= I_REG_WDATA[imugr_pkg::BIT_MOTION_EN];
        mot_mode_q <= I_REG_WDATA[imugr_pkg::BIT_MOTION_MODE];
        mot_rsv_q  <= I_REG_WDATA[imugr_pkg::BIT_MOTION_RSV0];
      end
      if (wr_host) begin
        fifo_en_q      <= I_REG_WDATA[imugr_pkg::BIT_FIFO_EN];
        two_wire_dis_q <= I_REG_WDATA[imugr_pkg::BIT_TWO_WIRE_DIS];
      end
      // self-clearing fifo reset, rounded up to whole cycles
      if (fifo_go) begin
        fifo_cnt_q <= imugr_pkg::FIFO_RST_CNT;
      end else if (fifo_on) begin
        fifo_cnt_q <= fifo_cnt_q - 2'h1;
      end
      if (I_REG_RD) begin
        rdata_q <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wake-on-motion
  wire hit = moved(I_ACCEL_X, ref_x_q, I_MOTION_THRESH) ||
             moved(I_ACCEL_Y, ref_y_q, I_MOTION_THRESH) ||
             moved(I_ACCEL_Z, ref_z_q, I_MOTION_THRESH);

  always_comb begin
    wom_d = wom_q;
    case (wom_q)
      imugr_pkg::IMUGR_WOM_IDLE: begin
        if (mot_en_q) begin
          wom_d = imugr_pkg::IMUGR_WOM_ARM;
        end
      end
      imugr_pkg::IMUGR_WOM_ARM: begin
        if (!mot_en_q) begin
          wom_d = imugr_pkg::IMUGR_WOM_IDLE;
        end else if (I_ACCEL_VALID) begin
          wom_d = imugr_pkg::IMUGR_WOM_RUN;
        end
      end
      imugr_pkg::IMUGR_WOM_RUN: begin
        if (!mot_en_q) begin
          wom_d = imugr_pkg::IMUGR_WOM_IDLE;
        end
      end
      default: wom_d = imugr_pkg::IMUGR_WOM_IDLE;
    endcase
  end

  // an accel-path reset drops to idle and re-arms a cycle later; the first sample in arm becomes the new reference
  wire run     = (wom_q == imugr_pkg::IMUGR_WOM_RUN);
  wire take_rf = I_ACCEL_VALID && ((wom_q == imugr_pkg::IMUGR_WOM_ARM) ||
                                   (run && mot_mode_q));

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      wom_q   <= imugr_pkg::IMUGR_WOM_IDLE;
      ref_x_q <= imugr_pkg::RATE_RESET;
      ref_y_q <= imugr_pkg::RATE_RESET;
      ref_z_q <= imugr_pkg::RATE_RESET;
      event_q <= 1'b0;
    end else if (I_CE) begin
      wom_q   <= (accel_rst_q || all_rst_q) ? imugr_pkg::IMUGR_WOM_IDLE : wom_d;
      event_q <= run && mot_en_q && I_ACCEL_VALID && hit;
      if (take_rf) begin
        ref_x_q <= I_ACCEL_X;
        ref_y_q <= I_ACCEL_Y;
        ref_z_q <= I_ACCEL_Z;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign O_REG_RDATA      = rdata_q;
  assign O_RATE_PATH_RST  = all_rst_q;
  assign O_ACCEL_PATH_RST = accel_rst_q || all_rst_q;
  assign O_TEMP_PATH_RST  = temp_rst_q || all_rst_q;
  assign O_FIFO_RST       = fifo_on;
  assign O_FIFO_HOST_EN   = fifo_en_q;
  assign O_TWO_WIRE_DIS   = two_wire_dis_q;
  assign O_MOTION_EVENT   = event_q;
  assign O_FIFO_RD_GRANT  = I_FIFO_RD_REQ && fifo_en_q;
  assign O_MOTION_IRQ     = event_q && (I_MOTION_IRQ_EN == imugr_pkg::IRQ_FIELD_ON);

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  property p_read_xh;
    I_CE && I_REG_RD && I_REG_ADDR == imugr_pkg::ADDR_RATE_XH |=>
      O_REG_RDATA == $past(rate_x_q[15:8]);
  endproperty
  a_read_xh: assert property (p_read_xh) else $error("x high byte read wrong");
  property p_read_yl;
    I_CE && I_REG_RD && I_REG_ADDR == imugr_pkg::ADDR_RATE_YL |=>
      O_REG_RDATA == $past(rate_y_q[7:0]);
  endproperty
  a_read_yl: assert property (p_read_yl) else $error("y low byte read wrong");
  property p_capture;
    I_CE && I_RATE_VALID && !all_go |=> rate_z_q == $past(I_RATE_Z) && rate_x_q == $past(I_RATE_X);
  endproperty
  a_capture: assert property (p_capture) else $error("rate sample not stored");
  property p_accel_keep;
    I_CE && wr_path && I_REG_WDATA[imugr_pkg::BIT_ACCEL_RST] && !I_RATE_VALID |=>
      O_ACCEL_PATH_RST && $stable(rate_x_q);
  endproperty
  a_accel_keep: assert property (p_accel_keep) else $error("accel reset wrong");
  property p_temp_keep;
    I_CE && wr_path && I_REG_WDATA[imugr_pkg::BIT_TEMP_RST] && !I_RATE_VALID |=>
      O_TEMP_PATH_RST && $stable(rate_y_q);
  endproperty
  a_temp_keep: assert property (p_temp_keep) else $error("temp reset wrong");
  property p_all_rst;
    I_CE && all_go |=> O_RATE_PATH_RST && O_ACCEL_PATH_RST && O_TEMP_PATH_RST
      && rate_x_q == imugr_pkg::RATE_RESET && rate_z_q == imugr_pkg::RATE_RESET;
  endproperty
  a_all_rst: assert property (p_all_rst) else $error("full reset wrong");
  property p_fifo_len;
    $fell(O_FIFO_RST) |-> $past(O_FIFO_RST, 3);
  endproperty
  a_fifo_len: assert property (p_fifo_len) else $error("fifo reset too short");
  property p_fifo_start;
    I_CE && fifo_go |=> O_FIFO_RST ##1 (O_FIFO_RST || !$past(I_CE));
  endproperty
  a_fifo_start: assert property (p_fifo_start) else $error("fifo reset missing");
  property p_spi_only;
    I_CE && wr_host |=> O_TWO_WIRE_DIS == $past(I_REG_WDATA[imugr_pkg::BIT_TWO_WIRE_DIS]) &&
      O_FIFO_HOST_EN == $past(I_REG_WDATA[imugr_pkg::BIT_FIFO_EN]);
  endproperty
  a_spi_only: assert property (p_spi_only) else $error("host control bits wrong");
  property p_no_grant;
    !O_FIFO_HOST_EN |-> !O_FIFO_RD_GRANT;
  endproperty
  a_no_grant: assert property (p_no_grant) else $error("fifo access while disabled");
  property p_wom_off;
    O_MOTION_EVENT && $past(I_CE) |-> $past(mot_en_q) && $past(I_ACCEL_VALID);
  endproperty
  a_wom_off: assert property (p_wom_off) else $error("event while disabled");
  property p_ref_first;
    I_CE && run && !mot_mode_q |=> $stable(ref_x_q);
  endproperty
  a_ref_first: assert property (p_ref_first) else $error("reference moved");
  property p_irq;
    O_MOTION_IRQ |-> I_MOTION_IRQ_EN == imugr_pkg::IRQ_FIELD_ON && O_MOTION_EVENT;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not gated");

  c_event: cover property (O_MOTION_IRQ);
  c_prev:  cover property (run && mot_mode_q && take_rf);
  c_fifo:  cover property (I_CE && fifo_go ##1 O_FIFO_RST[*3] ##1 !O_FIFO_RST);
  c_clear: cover property (I_CE && all_go && rate_x_q != 16'h0000);

endmodule : imugr_regs

// >>> core/imugr_pkg.sv
/*
  imugr_pkg: addresses, field positions, reset values, timing counts and
  state encoding for the angular-rate output and control register slice.
  Assumes a single 50 MHz core clock and an 8-bit register address space.
*/
package imugr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [7:0] ADDR_RATE_XH    = 8'h43;
  localparam logic [7:0] ADDR_RATE_XL    = 8'h44;
  localparam logic [7:0] ADDR_RATE_YH    = 8'h45;
  localparam logic [7:0] ADDR_RATE_YL    = 8'h46;
  localparam logic [7:0] ADDR_RATE_ZH    = 8'h47;
  localparam logic [7:0] ADDR_RATE_ZL    = 8'h48;
  localparam logic [7:0] ADDR_PATH_RST   = 8'h68;
  localparam logic [7:0] ADDR_MOTION_CTL = 8'h69;
  localparam logic [7:0] ADDR_HOST_CTL   = 8'h6a;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int BIT_ACCEL_RST     = 1;
  localparam int BIT_TEMP_RST      = 0;
  localparam int BIT_MOTION_EN     = 7;
  localparam int BIT_MOTION_MODE   = 6;
  localparam int BIT_MOTION_RSV0   = 0;
  localparam int BIT_FIFO_EN       = 6;
  localparam int BIT_TWO_WIRE_DIS  = 4;
  localparam int BIT_FIFO_RST      = 2;
  localparam int BIT_ALL_PATHS_RST = 0;

  ////////////////////////////////////////////////////////////////////////
  // reset values and codes
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [15:0] RATE_RESET     = 16'h0000;
  localparam logic [2:0]  IRQ_FIELD_ON   = 3'h7;
  localparam int          RATE_SENS_FS0  = 131;

  ////////////////////////////////////////////////////////////////////////
  // timing: fifo reset lasts at least one period of the 20 MHz internal clock
  localparam int CLK_PERIOD_NS    = 20;
  localparam int FIFO_RST_MIN_NS  = 50;
  localparam int FIFO_RST_CYC     = (FIFO_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] FIFO_RST_CNT = 2'(FIFO_RST_CYC);

  ////////////////////////////////////////////////////////////////////////
  // wake-on-motion sequencer
  typedef enum logic [1:0] {
    IMUGR_WOM_IDLE = 2'b00,
    IMUGR_WOM_ARM  = 2'b01,
    IMUGR_WOM_RUN  = 2'b11
  } imugr_wom_t;

endpackage : imugr_pkg

// >>> tb/imugr_host.sv
/*
  imugr_host: host-side model of the serial front end, driving the
  register strobe port. Assumes inputs are changed on the falling edge.
*/
`timescale 1ns/100ps
module imugr_host (
  // clock
  input  wire logic       i_clk,
  // register port
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic      [7:0] o_wdata,
  output logic            o_rd
);
  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // released lines show inverted data so stale values cannot match
  task put_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == imugr_pkg::ADDR_MOTION_CTL) v[imugr_pkg::BIT_MOTION_RSV0] = 1'b0;
    @(negedge i_clk);
    o_addr  = a;
    o_wdata = v;
    o_wr    = 1'b1;
    @(negedge i_clk);
    o_wr    = 1'b0;
    o_addr  = ~a;
    o_wdata = ~v;
  endtask : put_reg

  task get_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd   = 1'b1;
    @(negedge i_clk);
    d      = i_rdata;
    o_rd   = 1'b0;
    o_addr = ~a;
  endtask : get_reg
endmodule : imugr_host

// >>> tb/imugr_regs_tb_top.sv
/*
  imugr_regs_tb_top: directed register tests for the rate output and
  control slice. Assumes the host model above and a 50 MHz clock.
*/
`timescale 1ns/100ps
module imugr_regs_tb_top;
  logic        clk, rst_n, ce, rv, av, frq, wr, rd;
  logic [15:0] rx, ry, rz, ax, ay, az, thr;
  logic [2:0]  irqen;
  logic [7:0]  addr, wdata, rdata, d;
  logic        rpr, apr, tpr, frst, fen, twd, mev, mirq, grant;
  int          n_fail, n_compared, n;

  imugr_regs imugr_regs_inst (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
    .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata),
    .I_REG_RD(rd), .O_REG_RDATA(rdata),
    .I_RATE_VALID(rv), .I_RATE_X(rx), .I_RATE_Y(ry), .I_RATE_Z(rz),
    .I_ACCEL_VALID(av), .I_ACCEL_X(ax), .I_ACCEL_Y(ay),
    .I_ACCEL_Z(az), .I_MOTION_THRESH(thr), .I_MOTION_IRQ_EN(irqen),
    .I_FIFO_RD_REQ(frq), .O_FIFO_RD_GRANT(grant),
    .O_RATE_PATH_RST(rpr), .O_ACCEL_PATH_RST(apr), .O_TEMP_PATH_RST(tpr),
    .O_FIFO_RST(frst), .O_FIFO_HOST_EN(fen), .O_TWO_WIRE_DIS(twd),
    .O_MOTION_EVENT(mev), .O_MOTION_IRQ(mirq)
  );
  imugr_host imugr_host_inst (
    .i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
    .o_wdata(wdata), .o_rd(rd)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    imugr_host_inst.get_reg(a, d);
    chk("reg read", {8'h00, d}, {8'h00, e});
  endtask : rd_chk

  // bytes in address order, high byte first
  task chk_rates(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    logic [47:0] all;
    all = {x, y, z};
    for (int i = 0; i < 6; i++) begin
      rd_chk(imugr_pkg::ADDR_RATE_XH + 8'(i), all[47-8*i -: 8]);
    end
  endtask : chk_rates

  task acc(input logic [15:0] v, input logic ev);
    @(negedge clk);
    av = 1'b1;
    ax = v;
    @(posedge clk);
    #1;
    chk("motion event", {15'h0, mev}, {15'h0, ev});
    chk("motion irq", {15'h0, mirq}, {15'h0, ev & (irqen == imugr_pkg::IRQ_FIELD_ON)});
    @(negedge clk);
    av = 1'b0;
    ax = ~v;
  endtask : acc

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    {rst_n, rv, av, frq} = 4'h0;
    {rx, ry, rz, ax, ay, az} = 96'h0;
    ce = 1'b1;
    thr = 16'h0010;
    irqen = 3'h7;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    chk_rates(16'h0000, 16'h0000, 16'h0000);
    for (int i = 0; i < 3; i++) rd_chk(imugr_pkg::ADDR_PATH_RST + 8'(i), 8'h00);
    rd_chk(8'h00, 8'h00);
    $display("reset values done");
    // minus 1 dps reads as minus one sensitivity step
    @(negedge clk);
    rv = 1'b1;
    rx = 16'h1234;
    ry = 16'hff7d;
    rz = 16'h8000;
    @(negedge clk);
    rv = 1'b0;
    imugr_host_inst.put_reg(imugr_pkg::ADDR_RATE_XH, 8'haa);
    chk_rates(16'h1234, 16'hff7d, 16'h8000);
    $display("rate outputs done");
    imugr_host_inst.put_reg(imugr_pkg::ADDR_PATH_RST, 8'hff);
    chk("path pulses", {13'h0, rpr, apr, tpr}, 16'h0003);
    chk_rates(16'h1234, 16'hff7d, 16'h8000);
    rd_chk(imugr_pkg::ADDR_PATH_RST, 8'h00);
    $display("path reset done");
    frq = 1'b1;
    ce = 1'b0;
    imugr_host_inst.put_reg(imugr_pkg::ADDR_HOST_CTL, 8'h50);
    ce = 1'b1;
    chk("frozen write", {14'h0, fen, twd}, 16'h0000);
    imugr_host_inst.put_reg(imugr_pkg::ADDR_HOST_CTL, 8'h50);
    chk("fifo and spi", {13'h0, fen, twd, grant}, 16'h0007);
    rd_chk(imugr_pkg::ADDR_HOST_CTL, 8'h50);
    imugr_host_inst.put_reg(imugr_pkg::ADDR_HOST_CTL, 8'h00);
    chk("fifo blocked", {13'h0, fen, twd, grant}, 16'h0000);
    $display("host control done");
    imugr_host_inst.put_reg(imugr_pkg::ADDR_HOST_CTL, 8'h05);
    chk("full pulses", {13'h0, rpr, apr, tpr}, 16'h0007);
    n = 0;
    repeat (6) begin
      if (frst === 1'b1) n++;
      @(negedge clk);
    end
    chk("fifo reset len", 16'(n), 16'(imugr_pkg::FIFO_RST_CYC));
    rd_chk(imugr_pkg::ADDR_HOST_CTL, 8'h00);
    chk_rates(16'h0000, 16'h0000, 16'h0000);
    $display("full reset done");
    // no event before the reference sample is taken
    imugr_host_inst.put_reg(imugr_pkg::ADDR_MOTION_CTL, 8'h81);
    rd_chk(imugr_pkg::ADDR_MOTION_CTL, 8'h80);
    acc(16'h0300, 1'b0);
    acc(16'h0100, 1'b1);
    irqen = 3'h0;
    acc(16'h0100, 1'b1);
    irqen = 3'h7;
    imugr_host_inst.put_reg(imugr_pkg::ADDR_MOTION_CTL, 8'h00);
    acc(16'h7000, 1'b0);
    imugr_host_inst.put_reg(imugr_pkg::ADDR_MOTION_CTL, 8'hc0);
    acc(16'h0300, 1'b0);
    acc(16'h0100, 1'b1);
    acc(16'h0100, 1'b0);
    acc(16'h0110, 1'b0);
    acc(16'h0121, 1'b1);
    // any axis counts; y and z carry signed samples
    ay = 16'hff00;
    acc(16'h0121, 1'b1);
    az = 16'h0011;
    acc(16'h0121, 1'b1);
    acc(16'h0121, 1'b0);
    // accel path reset re-arms; the first sample lands in idle and is dropped, the second only sets the reference
    imugr_host_inst.put_reg(imugr_pkg::ADDR_PATH_RST, 8'h02);
    acc(16'h7000, 1'b0);
    acc(16'h7000, 1'b0);
    acc(16'h7100, 1'b1);
    $display("motion detect done");
    wrap_up();
  end
endmodule : imugr_regs_tb_top
